// >>> rtl/pfs_top.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_top (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_bit_mask,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // boot strap
    input wire logic ext_boot,
    // pins
    input wire logic [7:0] p9_in,
    output logic [7:0] p9_out,
    output logic [7:0] p9_oe_n,
    input wire logic [7:0] p10_in,
    output logic [7:0] p10_out,
    output logic [7:0] p10_oe_n,
    input wire logic [7:0] p11_in,
    output logic [7:0] p11_out,
    output logic [7:0] p11_oe_n,
    input wire logic [7:0] p12_in,
    output logic [7:0] p12_out,
    output logic [7:0] p12_oe_n,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_n,
    // bus unit
    input wire logic lower_write_or_col_strobe_n,
    input wire logic upper_write_or_col_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_enable_n,
    input wire logic bus_cycle_start_n,
    input wire logic output_enable_n,
    input wire logic bus_hold_acknowledge_n,
    output logic bus_hold_request_n,
    input wire logic [7:0] addr_lo,
    // pulse timer unit
    input wire logic timer_a_out0,
    input wire logic timer_a_out1,
    output logic timer_a_clear_in,
    output logic timer_a_count_in,
    input wire logic timer_b_out0,
    input wire logic timer_b_out1,
    output logic timer_b_clear_in,
    output logic timer_b_count_in,
    input wire logic timer_c_out0,
    input wire logic timer_c_out1,
    output logic timer_c_clear_in,
    output logic timer_c_count_in,
    // interrupts and dma
    output logic [3:0] ext_irq_a,
    output logic [3:0] ext_irq_b,
    output logic [3:0] ext_irq_c,
    input wire logic [3:0] dma_terminal_count,
    // clocked serial port
    input wire logic serial_port_clock_out,
    input wire logic serial_port_clock_oe_n,
    output logic serial_port_clock_in,
    input wire logic serial_port_out,
    output logic serial_port_in,
    // converter
    input wire logic converter_trigger_select,
    output logic converter_ext_trigger
);

    pfs_pkg::pfs_state_t r;
    pfs_pkg::pfs_state_t nxt;

    logic [`PFS_SYNC_W-1:0] sync_q;
    logic [`PFS_NPORT-1:0][7:0] pin_s;
    logic strap_s;
    logic [`PFS_NPORT-1:0][7:0] sel_v;
    logic [`PFS_NPORT-1:0][7:0] pout_v;
    logic [`PFS_NPORT-1:0][7:0] poen_v;
    logic [`PFS_NPORT-1:0][7:0] mux_out;
    logic [`PFS_NPORT-1:0][7:0] mux_oen;
    logic [`PFS_NPORT-1:0][7:0] pv;
    logic alt5;

    // masked write: single-bit access uses a one-hot mask
    function automatic logic [7:0] pfs_merge(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic [7:0] m
    );
        pfs_merge = (old & ~m) | (wd & m);
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pfs_sync u_sync (
        .clk(clk),
        .d({ext_boot, pa_in, p12_in, p11_in, p10_in, p9_in}),
        .q(sync_q)
    );

    assign pin_s = sync_q[`PFS_PINS_W-1:0];
    assign strap_s = sync_q[`PFS_STRAP_BIT];
    assign alt5 = r.alt11[`PFS_ALT11_BIT];

    // ----------------------------------------
    // pin multiplexers
    // ----------------------------------------
    always_comb
    begin
        sel_v[`PFS_P9] = r.fsel[`PFS_P9];
        pout_v[`PFS_P9] = {1'h1, bus_hold_acknowledge_n, output_enable_n,
            bus_cycle_start_n, write_enable_n, read_strobe_n,
            upper_write_or_col_strobe_n, lower_write_or_col_strobe_n};
        poen_v[`PFS_P9] = `PFS_P9_OEN;
        sel_v[`PFS_P10] = r.fsel[`PFS_P10];
        pout_v[`PFS_P10] = {dma_terminal_count, 2'h0, timer_a_out1, timer_a_out0};
        poen_v[`PFS_P10] = {~r.alt10[7:4], `PFS_P10_OEN_LO};
        // timer outputs, serial out and clock
        sel_v[`PFS_P11] = r.fsel[`PFS_P11];
        pout_v[`PFS_P11] = {serial_port_clock_out, 1'h0, serial_port_out,
            3'h0, timer_b_out1, timer_b_out0};
        poen_v[`PFS_P11] = {~alt5 | serial_port_clock_oe_n, 1'h1, ~alt5, 3'h7, 2'h0};
        sel_v[`PFS_P12] = r.fsel[`PFS_P12];
        pout_v[`PFS_P12] = {6'h00, timer_c_out1, timer_c_out0};
        poen_v[`PFS_P12] = `PFS_P12_OEN;
        // low address bus on port A
        sel_v[`PFS_PA] = {8{r.mm[`PFS_MM_ADDR_BIT]}};
        pout_v[`PFS_PA] = addr_lo;
        poen_v[`PFS_PA] = `PFS_ZERO8;
    end

    // peripheral drive replaces port latch and direction
    for (genvar g = 0; g < `PFS_NPORT; g++)
    begin : g_mux
        pfs_pin_mux u_mux (
            .sel(sel_v[g]),
            .per_out(pout_v[g]),
            .per_oe_n(poen_v[g]),
            .lat(r.lat[g]),
            .dir(r.dir[g]),
            .pin_out(mux_out[g]),
            .pin_oe_n(mux_oen[g])
        );
        // undriven pins read back their level
        assign pv[g] = (pin_s[g] & r.poen_n[g]) | (r.lat[g] & ~r.poen_n[g]);
    end

    // ----------------------------------------
    // registers and peripheral inputs
    // ----------------------------------------
    always_comb
    begin
        nxt = r;
        nxt.pout = mux_out;
        nxt.poen_n = mux_oen;
        nxt.rdata = `PFS_ZERO8;
        // masked writes give byte and bit access
        if (reg_wr)
        begin
            case (reg_addr)
                `PFS_A_P9_DATA: nxt.lat[`PFS_P9] = pfs_merge(r.lat[`PFS_P9], reg_wdata, reg_bit_mask);
                `PFS_A_P9_DIR: nxt.dir[`PFS_P9] = pfs_merge(r.dir[`PFS_P9], reg_wdata, reg_bit_mask);
                `PFS_A_P9_FSEL: nxt.fsel[`PFS_P9] = pfs_merge(r.fsel[`PFS_P9], reg_wdata, reg_bit_mask);
                `PFS_A_P10_DATA: nxt.lat[`PFS_P10] = pfs_merge(r.lat[`PFS_P10], reg_wdata, reg_bit_mask);
                `PFS_A_P10_DIR: nxt.dir[`PFS_P10] = pfs_merge(r.dir[`PFS_P10], reg_wdata, reg_bit_mask);
                `PFS_A_P10_FSEL: nxt.fsel[`PFS_P10] = pfs_merge(r.fsel[`PFS_P10], reg_wdata, reg_bit_mask);
                `PFS_A_P10_ALT: nxt.alt10 = pfs_merge(r.alt10, reg_wdata, reg_bit_mask) & `PFS_ALT10_MASK;
                `PFS_A_P11_DATA: nxt.lat[`PFS_P11] = pfs_merge(r.lat[`PFS_P11], reg_wdata, reg_bit_mask);
                `PFS_A_P11_DIR: nxt.dir[`PFS_P11] = pfs_merge(r.dir[`PFS_P11], reg_wdata, reg_bit_mask);
                `PFS_A_P11_FSEL: nxt.fsel[`PFS_P11] = pfs_merge(r.fsel[`PFS_P11], reg_wdata, reg_bit_mask);
                `PFS_A_P11_ALT: nxt.alt11 = pfs_merge(r.alt11, reg_wdata, reg_bit_mask) & `PFS_ALT11_MASK;
                `PFS_A_P12_DATA: nxt.lat[`PFS_P12] = pfs_merge(r.lat[`PFS_P12], reg_wdata, reg_bit_mask);
                `PFS_A_P12_DIR: nxt.dir[`PFS_P12] = pfs_merge(r.dir[`PFS_P12], reg_wdata, reg_bit_mask);
                `PFS_A_P12_FSEL: nxt.fsel[`PFS_P12] = pfs_merge(r.fsel[`PFS_P12], reg_wdata, reg_bit_mask);
                `PFS_A_PA_DATA: nxt.lat[`PFS_PA] = pfs_merge(r.lat[`PFS_PA], reg_wdata, reg_bit_mask);
                `PFS_A_PA_DIR: nxt.dir[`PFS_PA] = pfs_merge(r.dir[`PFS_PA], reg_wdata, reg_bit_mask);
                `PFS_A_MM: nxt.mm = 4'(pfs_merge({4'h0, r.mm}, reg_wdata, reg_bit_mask));
                default: nxt.mm = r.mm;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `PFS_A_P9_DATA: nxt.rdata = pv[`PFS_P9];
                `PFS_A_P9_DIR: nxt.rdata = r.dir[`PFS_P9];
                `PFS_A_P9_FSEL: nxt.rdata = r.fsel[`PFS_P9];
                `PFS_A_P10_DATA: nxt.rdata = pv[`PFS_P10];
                `PFS_A_P10_DIR: nxt.rdata = r.dir[`PFS_P10];
                `PFS_A_P10_FSEL: nxt.rdata = r.fsel[`PFS_P10];
                `PFS_A_P10_ALT: nxt.rdata = r.alt10;
                `PFS_A_P11_DATA: nxt.rdata = pv[`PFS_P11];
                `PFS_A_P11_DIR: nxt.rdata = r.dir[`PFS_P11];
                `PFS_A_P11_FSEL: nxt.rdata = r.fsel[`PFS_P11];
                `PFS_A_P11_ALT: nxt.rdata = r.alt11;
                `PFS_A_P12_DATA: nxt.rdata = pv[`PFS_P12];
                `PFS_A_P12_DIR: nxt.rdata = r.dir[`PFS_P12];
                `PFS_A_P12_FSEL: nxt.rdata = r.fsel[`PFS_P12];
                `PFS_A_PA_DATA: nxt.rdata = pv[`PFS_PA];
                `PFS_A_PA_DIR: nxt.rdata = r.dir[`PFS_PA];
                `PFS_A_MM: nxt.rdata = {4'h0, r.mm};
                default: nxt.rdata = `PFS_ZERO8;
            endcase
        end
        nxt.tclr = {r.fsel[`PFS_P12][2] & pin_s[`PFS_P12][2],
            r.fsel[`PFS_P11][2] & pin_s[`PFS_P11][2],
            r.fsel[`PFS_P10][2] & pin_s[`PFS_P10][2]};
        nxt.tcnt = {r.fsel[`PFS_P12][3] & pin_s[`PFS_P12][3],
            r.fsel[`PFS_P11][3] & pin_s[`PFS_P11][3],
            r.fsel[`PFS_P10][3] & pin_s[`PFS_P10][3]};
        // choice counts only in peripheral mode
        nxt.irq_a = r.fsel[`PFS_P10][7:4] & ~r.alt10[7:4] & pin_s[`PFS_P10][7:4];
        nxt.irq_b = {r.fsel[`PFS_P11][7:5] & {3{~alt5}} & pin_s[`PFS_P11][7:5],
            r.fsel[`PFS_P11][4] & pin_s[`PFS_P11][4]};
        nxt.ser_in = r.fsel[`PFS_P11][6] & alt5 & pin_s[`PFS_P11][6];
        nxt.ser_clk_in = r.fsel[`PFS_P11][7] & alt5 & pin_s[`PFS_P11][7];
        nxt.irq_c = r.fsel[`PFS_P12][7:4] & pin_s[`PFS_P12][7:4];
        // pin 7 doubles as converter trigger
        nxt.conv_trig = r.fsel[`PFS_P12][`PFS_TRG_PIN] & converter_trigger_select
            & pin_s[`PFS_P12][`PFS_TRG_PIN];
        // hold request idles high when not selected
        nxt.hold_req_n = ~r.fsel[`PFS_P9][`PFS_HOLD_PIN] | pin_s[`PFS_P9][`PFS_HOLD_PIN];
        if (reset)
        begin
            for (int i = 0; i < `PFS_NPORT; i++)
            begin
                nxt.lat[i] = `PFS_ZERO8;
                nxt.dir[i] = `PFS_RST_DIR;
                nxt.pout[i] = `PFS_ZERO8;
                nxt.poen_n[i] = `PFS_ONES8;
            end
            nxt.fsel = '0;
            nxt.alt10 = `PFS_ZERO8;
            nxt.alt11 = `PFS_ZERO8;
            // expansion boot starts with bus enabled
            nxt.fsel[`PFS_P9] = strap_s ? `PFS_RST_P9_EXT : `PFS_ZERO8;
            nxt.mm = strap_s ? `PFS_MM_EXT : `PFS_MM_ZERO;
            nxt.rdata = `PFS_ZERO8;
            nxt.irq_a = 4'h0;
            nxt.irq_b = 4'h0;
            nxt.irq_c = 4'h0;
            nxt.tclr = 3'h0;
            nxt.tcnt = 3'h0;
            nxt.ser_in = 1'h0;
            nxt.ser_clk_in = 1'h0;
            nxt.hold_req_n = 1'h1;
            nxt.conv_trig = 1'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        r <= nxt;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = r.rdata;
    assign p9_out = r.pout[`PFS_P9];
    assign p9_oe_n = r.poen_n[`PFS_P9];
    assign p10_out = r.pout[`PFS_P10];
    assign p10_oe_n = r.poen_n[`PFS_P10];
    assign p11_out = r.pout[`PFS_P11];
    assign p11_oe_n = r.poen_n[`PFS_P11];
    assign p12_out = r.pout[`PFS_P12];
    assign p12_oe_n = r.poen_n[`PFS_P12];
    assign pa_out = r.pout[`PFS_PA];
    assign pa_oe_n = r.poen_n[`PFS_PA];
    assign bus_hold_request_n = r.hold_req_n;
    assign timer_a_clear_in = r.tclr[0];
    assign timer_b_clear_in = r.tclr[1];
    assign timer_c_clear_in = r.tclr[2];
    assign timer_a_count_in = r.tcnt[0];
    assign timer_b_count_in = r.tcnt[1];
    assign timer_c_count_in = r.tcnt[2];
    assign ext_irq_a = r.irq_a;
    assign ext_irq_b = r.irq_b;
    assign ext_irq_c = r.irq_c;
    assign serial_port_in = r.ser_in;
    assign serial_port_clock_in = r.ser_clk_in;
    assign converter_ext_trigger = r.conv_trig;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence fsel10_write_s;
        reg_wr && reg_addr == `PFS_A_P10_FSEL && reg_bit_mask == `PFS_ONES8;
    endsequence

    sequence fsel10_read_s;
        reg_rd && reg_addr == `PFS_A_P10_FSEL;
    endsequence

    p9_strobe_a: assert property (r.fsel[`PFS_P9][4] |=>
        p9_out[4] == $past(bus_cycle_start_n) && !p9_oe_n[4])
        else $error("port9 pin4 not bus cycle start");
    p9_gpio_a: assert property (!r.fsel[`PFS_P9][0] |=>
        p9_out[0] == $past(r.lat[`PFS_P9][0]) && p9_oe_n[0] == $past(r.dir[`PFS_P9][0]))
        else $error("port9 pin0 not from latch");
    p10_dma_a: assert property (r.fsel[`PFS_P10][4] && r.alt10[4] |=>
        p10_out[4] == $past(dma_terminal_count[0]) && !p10_oe_n[4])
        else $error("port10 pin4 not dma count");
    irq_gated_a: assert property (!r.fsel[`PFS_P10][5] |=> !ext_irq_a[1])
        else $error("irq seen in port mode");
    alt_fixed_a: assert property (reg_rd && reg_addr == `PFS_A_P11_ALT |=>
        (reg_rdata & ~`PFS_ALT11_MASK) == `PFS_ZERO8)
        else $error("port11 choice fixed bits set");
    alt10_fixed_a: assert property (reg_wr && reg_addr == `PFS_A_P10_ALT |=>
        r.alt10[3:0] == 4'h0)
        else $error("port10 choice low bits set");
    dir_reset_a: assert property (disable iff (1'h0) reset |=>
        r.dir[`PFS_P11] == `PFS_RST_DIR && r.alt11 == `PFS_ZERO8)
        else $error("port11 reset values wrong");
    pa_addr_a: assert property (r.mm[`PFS_MM_ADDR_BIT] |=>
        pa_out == $past(addr_lo) && pa_oe_n == `PFS_ZERO8)
        else $error("port A not address bus");
    conv_trig_a: assert property (r.fsel[`PFS_P12][7] && converter_trigger_select
        && pin_s[`PFS_P12][7] |=> converter_ext_trigger && ext_irq_c[3])
        else $error("converter trigger missing");
    fsel_rw_a: assert property (fsel10_write_s ##1 fsel10_read_s |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("port10 select readback wrong");
    ser_clk_a: assert property (r.fsel[`PFS_P11][7] && alt5 |=>
        p11_oe_n[7] == $past(serial_port_clock_oe_n))
        else $error("serial clock enable wrong");
    readback_a: assert property (reg_rd && reg_addr == `PFS_A_P12_DATA
        && r.poen_n[`PFS_P12] == `PFS_ONES8 |=> reg_rdata == $past(pin_s[`PFS_P12]))
        else $error("port12 readback not pin level");

endmodule

// >>> rtl/pfs_defs.svh
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define PFS_NPORT 5
`define PFS_NFSEL 4
`define PFS_PINS_W 40
`define PFS_SYNC_W 41
`define PFS_STRAP_BIT 40

// port indices
`define PFS_P9 0
`define PFS_P10 1
`define PFS_P11 2
`define PFS_P12 3
`define PFS_PA 4

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PFS_A_P9_DATA 32'hFFFFF800
`define PFS_A_P9_DIR 32'hFFFFF801
`define PFS_A_P9_FSEL 32'hFFFFF802
`define PFS_A_P10_DATA 32'hFFFFF810
`define PFS_A_P10_DIR 32'hFFFFF811
`define PFS_A_P10_FSEL 32'hFFFFF812
`define PFS_A_P10_ALT 32'hFFFFF594
`define PFS_A_P11_DATA 32'hFFFFF820
`define PFS_A_P11_DIR 32'hFFFFF036
`define PFS_A_P11_FSEL 32'h0FFFF056
`define PFS_A_P11_ALT 32'hFFFFF596
`define PFS_A_P12_DATA 32'hFFFFF830
`define PFS_A_P12_DIR 32'hFFFFF831
`define PFS_A_P12_FSEL 32'hFFFFF832
`define PFS_A_PA_DATA 32'hFFFFF840
`define PFS_A_PA_DIR 32'hFFFFF841
`define PFS_A_MM 32'hFFFFF850

// ----------------------------------------
// reset values and fixed fields
// ----------------------------------------
`define PFS_ZERO8 8'h00
`define PFS_ONES8 8'hFF
`define PFS_RST_DIR 8'hFF
`define PFS_RST_P9_EXT 8'hFF
`define PFS_MM_EXT 4'h7
`define PFS_MM_ZERO 4'h0
`define PFS_ALT10_MASK 8'hF0
`define PFS_ALT11_MASK 8'h20
`define PFS_ALT11_BIT 5
`define PFS_MM_ADDR_BIT 2
`define PFS_HOLD_PIN 7
`define PFS_TRG_PIN 7
`define PFS_P9_OEN 8'h80
`define PFS_P12_OEN 8'hFC
`define PFS_P10_OEN_LO 4'hC

`endif

// >>> rtl/pfs_pkg.sv
`include "pfs_defs.svh"

package pfs_pkg;

    typedef struct packed {
        logic [`PFS_SYNC_W-1:0] s1;
        logic [`PFS_SYNC_W-1:0] s2;
    } pfs_sync_state_t;

    typedef struct packed {
        logic [`PFS_NPORT-1:0][7:0] lat;
        logic [`PFS_NPORT-1:0][7:0] dir;
        logic [`PFS_NFSEL-1:0][7:0] fsel;
        logic [7:0] alt10;
        logic [7:0] alt11;
        logic [3:0] mm;
        logic [7:0] rdata;
        logic [`PFS_NPORT-1:0][7:0] pout;
        logic [`PFS_NPORT-1:0][7:0] poen_n;
        logic [3:0] irq_a;
        logic [3:0] irq_b;
        logic [3:0] irq_c;
        logic [2:0] tclr;
        logic [2:0] tcnt;
        logic ser_in;
        logic ser_clk_in;
        logic hold_req_n;
        logic conv_trig;
    } pfs_state_t;

endpackage

// >>> rtl/pfs_sync.sv
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_sync (
    // clock
    input wire logic clk,
    // data
    input wire logic [`PFS_SYNC_W-1:0] d,
    output logic [`PFS_SYNC_W-1:0] q
);

    pfs_pkg::pfs_sync_state_t r;
    pfs_pkg::pfs_sync_state_t nxt;

    // two stages; only the second stage is read
    always_comb
    begin
        nxt = r;
        nxt.s1 = d;
        nxt.s2 = r.s1;
    end

    always_ff @(posedge clk)
    begin
        r <= nxt;
    end

    assign q = r.s2;

endmodule

// >>> rtl/pfs_pin_mux.sv
`timescale 1ns/1ps

module pfs_pin_mux (
    // selection
    input wire logic [7:0] sel,
    // peripheral side
    input wire logic [7:0] per_out,
    input wire logic [7:0] per_oe_n,
    // port side
    input wire logic [7:0] lat,
    input wire logic [7:0] dir,
    // pin side
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n
);

    for (genvar b = 0; b < 8; b++)
    begin : g_bit
        assign pin_out[b] = sel[b] ? per_out[b] : lat[b];
        assign pin_oe_n[b] = sel[b] ? per_oe_n[b] : dir[b];
    end

endmodule

// >>> dv/pfs_board.sv
`timescale 1ns/1ps

module pfs_board (
    // design side
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe_n,
    // board drive
    input wire logic [39:0] drive,
    // resolved pin level
    output logic [39:0] level
);
    // ----------------------------------------
    // pin resolution
    // ----------------------------------------
    // driver wins, else board
    always_comb
    begin
        for (int i = 0; i < 40; i++)
        begin
            level[i] = pin_oe_n[i] ? drive[i] : pin_out[i];
        end
    end
endmodule

// >>> dv/port_function_select_bench.sv
`timescale 1ns/1ps
`include "pfs_defs.svh"

module port_function_select_bench;
    logic clk, reset, reg_wr, reg_rd, ext_boot, conv_sel;
    logic [31:0] reg_addr;
    logic [7:0] reg_wdata, reg_bit_mask, addr_lo;
    logic [6:0] bstb;
    logic [5:0] tmo;
    logic [3:0] dma;
    logic [2:0] ser;
    logic [39:0] bd;
    wire [7:0] reg_rdata;
    wire [5:0] tin;
    wire [3:0] irq_a, irq_b, irq_c;
    wire [1:0] ser_in;
    wire hold_n, conv_trig;
    wire [39:0] pout, poen, lvl;
    int bad_count, total_checks, cyc;

    pfs_top pfs_top_i (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_bit_mask(reg_bit_mask), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_boot(ext_boot),
        .p9_in(lvl[7:0]), .p9_out(pout[7:0]), .p9_oe_n(poen[7:0]),
        .p10_in(lvl[15:8]), .p10_out(pout[15:8]), .p10_oe_n(poen[15:8]),
        .p11_in(lvl[23:16]), .p11_out(pout[23:16]), .p11_oe_n(poen[23:16]),
        .p12_in(lvl[31:24]), .p12_out(pout[31:24]), .p12_oe_n(poen[31:24]),
        .pa_in(lvl[39:32]), .pa_out(pout[39:32]), .pa_oe_n(poen[39:32]),
        .lower_write_or_col_strobe_n(bstb[0]), .upper_write_or_col_strobe_n(bstb[1]),
        .read_strobe_n(bstb[2]), .write_enable_n(bstb[3]), .bus_cycle_start_n(bstb[4]),
        .output_enable_n(bstb[5]), .bus_hold_acknowledge_n(bstb[6]),
        .bus_hold_request_n(hold_n), .addr_lo(addr_lo),
        .timer_a_out0(tmo[0]), .timer_a_out1(tmo[1]), .timer_a_clear_in(tin[0]),
        .timer_a_count_in(tin[1]), .timer_b_out0(tmo[2]), .timer_b_out1(tmo[3]),
        .timer_b_clear_in(tin[2]), .timer_b_count_in(tin[3]), .timer_c_out0(tmo[4]),
        .timer_c_out1(tmo[5]), .timer_c_clear_in(tin[4]), .timer_c_count_in(tin[5]),
        .ext_irq_a(irq_a), .ext_irq_b(irq_b), .ext_irq_c(irq_c),
        .dma_terminal_count(dma), .serial_port_clock_out(ser[2]),
        .serial_port_clock_oe_n(ser[1]), .serial_port_clock_in(ser_in[1]),
        .serial_port_out(ser[0]), .serial_port_in(ser_in[0]),
        .converter_trigger_select(conv_sel), .converter_ext_trigger(conv_trig)
    );

    pfs_board pfs_board_i (.pin_out(pout), .pin_oe_n(poen), .drive(bd), .level(lvl));

    // ----------------------------------------
    // clock, timeout, shared tasks
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            report_and_stop;
        end
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_bit_mask <= m;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rdc(input logic [31:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask

    // byte write followed at once by a read of the same register
    task wrrd(input logic [31:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_bit_mask <= 8'hFF;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask

    task settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rdc(`PFS_A_P11_DIR, 8'hFF);
        rdc(`PFS_A_P11_FSEL, 8'h00);
        rdc(`PFS_A_P10_ALT, 8'h00);
        rdc(`PFS_A_P11_ALT, 8'h00);
        rdc(`PFS_A_MM, 8'h07);
        rdc(`PFS_A_P9_FSEL, 8'hFF);
        rdc(32'hFFFFF8F0, 8'h00);
    endtask

    task t_bus9;
        @(posedge clk);
        bstb <= 7'h55;
        settle;
        chk({1'b0, pout[6:0]}, 8'h55);
        chk(poen[7:0], 8'h80);
        chk({7'h00, hold_n}, 8'h00);
        wr(`PFS_A_P9_FSEL, 8'h00, 8'hFF);
        settle;
        chk(poen[7:0], 8'hFF);
        chk({7'h00, hold_n}, 8'h01);
    endtask

    task t_alt;
        wr(`PFS_A_P10_ALT, 8'hFF, 8'hFF);
        rdc(`PFS_A_P10_ALT, 8'hF0);
        wr(`PFS_A_P11_ALT, 8'hFF, 8'hFF);
        rdc(`PFS_A_P11_ALT, 8'h20);
        wr(`PFS_A_P11_DIR, 8'h00, 8'h01);
        rdc(`PFS_A_P11_DIR, 8'hFE);
        wr(`PFS_A_P11_DIR, 8'hFF, 8'h01);
    endtask

    task t_p10;
        wrrd(`PFS_A_P10_FSEL, 8'hFF, 8'hFF);
        @(posedge clk);
        dma <= 4'h9;
        tmo <= 6'h02;
        bd[15:8] <= 8'hAF;
        settle;
        chk({pout[15:12], 2'b00, pout[9:8]}, 8'h92);
        chk(poen[15:8], 8'h0C);
        chk({6'h00, tin[1:0]}, 8'h03);
        wr(`PFS_A_P10_ALT, 8'h00, 8'hFF);
        settle;
        chk({4'h0, irq_a}, 8'h0A);
        chk(poen[15:8], 8'hFC);
        wr(`PFS_A_P10_FSEL, 8'h00, 8'hFF);
        wr(`PFS_A_P10_ALT, 8'hF0, 8'hFF);
        settle;
        chk(poen[15:8], 8'hFF);
        chk({2'b00, tin[1:0], irq_a}, 8'h00);
    endtask

    task t_p11;
        wr(`PFS_A_P11_FSEL, 8'hFF, 8'hFF);
        @(posedge clk);
        tmo[3:2] <= 2'b01;
        ser <= 3'b101;
        bd[23:16] <= 8'h5C;
        settle;
        chk({pout[23], 1'b0, pout[21], 3'b000, pout[17:16]}, 8'hA1);
        chk({6'h00, ser_in}, 8'h03);
        chk({5'h00, tin[3:2], irq_b[0]}, 8'h07);
        wr(`PFS_A_P11_ALT, 8'h00, 8'hFF);
        settle;
        chk({4'h0, irq_b}, 8'h05);
        rdc(`PFS_A_P11_DATA, 8'h5C);
    endtask

    task t_p12;
        @(posedge clk);
        bd[31:24] <= 8'hDC;
        settle;
        rdc(`PFS_A_P12_DATA, 8'hDC);
        wr(`PFS_A_P12_FSEL, 8'hFF, 8'hFF);
        @(posedge clk);
        tmo[5:4] <= 2'b10;
        conv_sel <= 1'b1;
        bd[31:24] <= 8'hDC;
        settle;
        chk({6'h00, pout[25:24]}, 8'h02);
        chk({2'b00, tin[5:4], irq_c}, 8'h3D);
        chk({7'h00, conv_trig}, 8'h01);
        @(posedge clk);
        conv_sel <= 1'b0;
        settle;
        chk({7'h00, conv_trig}, 8'h00);
        wr(`PFS_A_P12_FSEL, 8'h00, 8'hFF);
        wr(`PFS_A_P12_DATA, 8'h05, 8'hFF);
        wr(`PFS_A_P12_DIR, 8'hF0, 8'hFF);
        settle;
        chk(poen[31:24], 8'hF0);
        chk({4'h0, pout[27:24]}, 8'h05);
    endtask

    task t_pa;
        @(posedge clk);
        addr_lo <= 8'h3C;
        bd[39:32] <= 8'hA5;
        settle;
        chk(pout[39:32], 8'h3C);
        chk(poen[39:32], 8'h00);
        wr(`PFS_A_MM, 8'h0B, 8'hFF);
        settle;
        chk(poen[39:32], 8'hFF);
        wr(`PFS_A_MM, 8'h0C, 8'hFF);
        settle;
        chk(poen[39:32], 8'h00);
        wr(`PFS_A_MM, 8'h00, 8'hFF);
        settle;
        rdc(`PFS_A_PA_DATA, 8'hA5);
    endtask

    // mid-run reset with the strap low: port mode boot
    task t_boot;
        @(posedge clk);
        reset <= 1'b1;
        ext_boot <= 1'b0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rdc(`PFS_A_MM, 8'h00);
        rdc(`PFS_A_P9_FSEL, 8'h00);
        rdc(`PFS_A_P10_ALT, 8'h00);
        rdc(`PFS_A_P11_DIR, 8'hFF);
    endtask

    initial
    begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 32'h00000000;
        reg_wdata = 8'h00;
        reg_bit_mask = 8'hFF;
        ext_boot = 1'b1;
        conv_sel = 1'b0;
        addr_lo = 8'h00;
        bstb = 7'h7F;
        tmo = 6'h00;
        dma = 4'h0;
        ser = 3'b010;
        bd = 40'h0000000000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_bus9;
        t_alt;
        t_p10;
        t_p11;
        t_p12;
        t_pa;
        t_boot;
        report_and_stop;
    end
endmodule
